// file: ess_pkg.sv
// Purpose: constants and types for the serial slave port of the ecg front end
// Assumes: 100 MHz system clock; link pins sampled by that clock
// Notes:   command word = rw flag, 7-bit address, 24-bit data, msb first
package ess_pkg;

  // system clock rate, used to derive the secondary port divider
  localparam int CLK_KHZ = 100000;

  // command word layout
  localparam int RW_BIT  = 31;              // 1 = write, 0 = read
  localparam int ADDR_HI = 30;              // address field top
  localparam int ADDR_LO = 24;              // address field bottom
  localparam int DATA_HI = 23;              // data field top
  localparam logic [4:0] LAST_BIT = 5'h1f;  // bit count of the 32nd bit

  // register addresses with special meaning to the port
  localparam logic [6:0] ADDR_NOP   = 7'h00;  // address zero with either rw, keeps frames
  localparam logic [6:0] ADDR_FRAME = 7'h40;  // read here starts framing

  // resync: this many high bits in a row arm the word hunt
  localparam int         RESYNC_ONES = 64;
  localparam logic [6:0] ONES_LAST   = 7'(RESYNC_ONES - 1);

  // secondary master port: 20.48 MHz target, divider truncates to a 25 MHz clock (clk/4), 16-bit words
  localparam int SEC_SCLK_KHZ = 20480;
  localparam int SEC_HALF_RAW = CLK_KHZ / (2 * SEC_SCLK_KHZ);
  localparam int SEC_HALF     = (SEC_HALF_RAW < 1) ? 1 : SEC_HALF_RAW;
  localparam logic [1:0] SEC_DIV_LAST = 2'(SEC_HALF - 1);

  // link state, gray coded along idle -> word -> hunt
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_WORD = 2'b01,
    LK_HUNT = 2'b11
  } ess_link_t;

  // whole state of the port
  typedef struct packed {
    logic        csS1;     // chip select sync stage 1
    logic        csS2;     // chip select sync stage 2
    logic        csD;      // delayed for edge detect
    logic        ckS1;     // serial clock sync stage 1
    logic        ckS2;     // serial clock sync stage 2
    logic        ckD;      // delayed for edge detect
    logic        diS1;     // data in sync stage 1
    logic        diS2;     // data in sync stage 2
    ess_link_t   link;     // link state
    logic [4:0]  bitCnt;   // bits taken in the current word
    logic [30:0] rxSh;     // receive shifter
    logic [6:0]  onesCnt;  // consecutive high bits
    logic        wrPend;   // write waiting for its commit point
    logic        rdPend;   // read answer due in next word
    logic        framing;  // frame streaming enabled
    logic        full;     // frame buffer holds an unread frame
    logic [3:0]  frmIdx;   // next frame word to send
    logic [31:0] txSh;     // transmit shifter
    logic        sdo;      // serial data out level
    logic [6:0]  cmdAddr;  // last command address
    logic [23:0] cmdData;  // last write data
    logic        wrStb;    // register write pulse
    logic        rdyN;     // frame ready, low = ready
    logic        secRun;   // secondary port busy
    logic        secSclk;  // secondary clock level
    logic        secCsN;   // secondary select
    logic        secSdo;   // secondary data
    logic [1:0]  secDiv;   // half period counter
    logic [3:0]  secBit;   // bit within 16-bit word
    logic [3:0]  secIdx;   // next secondary word
    logic [14:0] secSh;    // secondary shifter
  } ess_state_t;

  // reset image: selects and clocks idle high, ready held busy
  localparam ess_state_t ESS_STATE_RST = '{
    csS1: 1'b1, csS2: 1'b1, csD: 1'b1,
    ckS1: 1'b1, ckS2: 1'b1, ckD: 1'b1,
    link: LK_IDLE, rdyN: 1'b1, secCsN: 1'b1, secSclk: 1'b1,
    default: '0
  };

endpackage : ess_pkg

// file: ess_serial_port.sv
// Purpose: serial slave port of a multichannel ecg front end
// Assumes: link clock well below clk/4 so the sampled edges are seen
// Notes:   core supplies frame words by index and register read data by address
//
// Overview of operation
// - chip select high: input data ignored
// - output enable off while chip select high
// - 64 high bits then low bit resyncs
// - slow-rate frame words start with address
// - input sampled on serial clock rising edge
// - output changes on serial clock falling edge
// - ready low means ready, high in reset
// - framing: ready high empty, low full
// - no framing: ready stays low
// - ready returns high after whole packet read
// - write is one 32-bit word, msb first
// - works with free-running or gated clock
// - transfer starts at chip select fall
// - commit at select rise or next word
// - writes accepted during frame streaming
// - serial clock up to 40 MHz; this port needs it well below clk/4
// - secondary master port at 20.48 MHz clock; this port generates 25 MHz (clk/4)
// - slow-rate words are 32-bit address plus data
// - rw bit 31, address 30:24, data 23:0
// - read data shifted out in next word
`timescale 1ns/100ps
`default_nettype none

module ess_serial_port
(
  input  wire logic        clk,          // system clock
  input  wire logic        arst_n,       // async reset, active low
  input  wire logic        cs_n,         // chip select pin
  input  wire logic        sclk,         // serial clock pin
  input  wire logic        sdi,          // serial data in pin
  output logic             sdo,          // serial data out
  output logic             sdoOe,        // serial data out drive enable
  output logic             frameReady_n, // frame ready, low = ready
  input  wire logic        frameAvail,   // pulse: core filled a frame
  input  wire logic [3:0]  frameLen,     // words per frame, 1..10
  output logic [3:0]       frmIdx,       // frame word being fetched
  input  wire logic [6:0]  frmAddr,      // address of that word
  input  wire logic [23:0] frmData,      // data of that word
  output logic             regWrStb,     // register write pulse
  output logic [6:0]       regWrAddr,    // register write address
  output logic [23:0]      regWrData,    // register write data
  output logic [6:0]       regRdAddr,    // register read address
  input  wire logic [23:0] regRdData,    // register read data
  input  wire logic        secEn,        // enable secondary port
  output logic [3:0]       secIdx,       // secondary word being fetched
  input  wire logic [15:0] secData,      // secondary word, 16 bits
  output logic             secSclk,      // secondary serial clock
  output logic             secSdo,       // secondary serial data
  output logic             secCs_n       // secondary frame select
);

  ess_pkg::ess_state_t q;      // registered state
  ess_pkg::ess_state_t n;      // next state
  logic                riseEv; // sampled serial clock rising edge
  logic                fallEv; // sampled serial clock falling edge
  logic                csRise; // sampled select release
  logic                startRs;// first rising edge of a word
  logic [31:0]         rxWord; // completed word
  logic [31:0]         txWord; // word chosen for output

  // edges are found on the second sync stage only; the clock may stop
  // between bursts, so nothing counts on a free-running link clock
  assign riseEv  = q.ckS2 & ~q.ckD;
  assign fallEv  = ~q.ckS2 & q.ckD;
  assign csRise  = q.csS2 & ~q.csD;
  assign startRs = riseEv & ~q.csS2 & (q.bitCnt == 5'h00);
  assign rxWord  = {q.rxSh, q.diS2};

  // next-state logic for the whole port
  always_comb
  begin
    n        = q;
    txWord   = 32'h0000_0000;
    // two-stage synchronisers on every pin
    n.csS1   = cs_n;
    n.csS2   = q.csS1;
    n.csD    = q.csS2;
    n.ckS1   = sclk;
    n.ckS2   = q.ckS1;
    n.ckD    = q.ckS2;
    n.diS1   = sdi;
    n.diS2   = q.diS1;
    n.wrStb  = 1'b0;

    // pending write lands at select release or first edge of next word
    if (q.wrPend && (csRise || startRs))
    begin
      n.wrStb  = 1'b1;
      n.wrPend = 1'b0;
    end

    if (q.csS2)
    begin
      // deselected: drop any partial word, input is ignored
      n.link    = ess_pkg::LK_IDLE;
      n.bitCnt  = 5'h00;
      n.onesCnt = 7'h00;
    end
    else
    begin
      if (q.link == ess_pkg::LK_IDLE)
      begin
        n.link = ess_pkg::LK_WORD;
      end
      if (riseEv)
      begin
        // run of high bits for the resync detector
        if (!q.diS2)
        begin
          n.onesCnt = 7'h00;
        end
        else if (q.onesCnt != ess_pkg::ONES_LAST)
        begin
          n.onesCnt = q.onesCnt + 7'h01;
        end
        if (q.link == ess_pkg::LK_HUNT && q.diS2)
        begin
          // hunting: high bits carry no word
          n.bitCnt = 5'h00;
        end
        else if (q.diS2 && q.onesCnt == ess_pkg::ONES_LAST)
        begin
          // 64th high bit: realign on the next low bit
          n.link   = ess_pkg::LK_HUNT;
          n.bitCnt = 5'h00;
        end
        else
        begin
          // msb first shift of the incoming word
          n.link   = ess_pkg::LK_WORD;
          n.rxSh   = {q.rxSh[29:0], q.diS2};
          n.bitCnt = q.bitCnt + 5'h01;
          if (q.bitCnt == ess_pkg::LAST_BIT)
          begin
            // full word in: decode rw, address, data
            n.cmdAddr = rxWord[ess_pkg::ADDR_HI:ess_pkg::ADDR_LO];
            if (rxWord[ess_pkg::ADDR_HI:ess_pkg::ADDR_LO]
                == ess_pkg::ADDR_NOP)
            begin
              // nop in either polarity: an all-zero word keeps frames
              // running, so a host can clock frames out with sdi low
              n.cmdAddr = q.cmdAddr;
            end
            else if (rxWord[ess_pkg::RW_BIT])
            begin
              // write; framing kept running
              n.cmdData = rxWord[ess_pkg::DATA_HI:0];
              n.wrPend  = 1'b1;
            end
            else if (rxWord[ess_pkg::ADDR_HI:ess_pkg::ADDR_LO]
                     == ess_pkg::ADDR_FRAME)
            begin
              // read of the frame header starts streaming
              n.framing = 1'b1;
              n.rdPend  = 1'b0;
            end
            else
            begin
              // register read interrupts framing
              n.framing = 1'b0;
              n.full    = 1'b0;
              n.frmIdx  = 4'h0;
              n.rdPend  = 1'b1;
            end
          end
        end
      end

      if (fallEv)
      begin
        if (q.bitCnt == 5'h00 && q.link != ess_pkg::LK_HUNT)
        begin
          // word boundary: choose what the next word carries
          if (q.rdPend)
          begin
            txWord   = {1'b0, q.cmdAddr, regRdData};
            n.rdPend = 1'b0;
          end
          else if (q.framing && q.full)
          begin
            // address leads every frame word
            txWord = {1'b0, frmAddr, frmData};
            if (q.frmIdx == frameLen - 4'h1)
            begin
              // last word read: buffer empty again
              n.full   = 1'b0;
              n.frmIdx = 4'h0;
            end
            else
            begin
              n.frmIdx = q.frmIdx + 4'h1;
            end
          end
          n.sdo  = txWord[31];
          n.txSh = {txWord[30:0], 1'b0};
        end
        else
        begin
          n.sdo  = q.txSh[31];
          n.txSh = {q.txSh[30:0], 1'b0};
        end
      end
    end

    // a fresh frame wins over the drain of the old one
    if (frameAvail && q.framing)
    begin
      n.full = 1'b1;
    end
    // ready: busy while empty, ready when full or not framing
    n.rdyN = n.framing ? ~n.full : 1'b0;

    // secondary master port: streams 16-bit words of each frame
    if (!q.secRun)
    begin
      if (secEn && frameAvail)
      begin
        n.secRun  = 1'b1;
        n.secCsN  = 1'b0;
        n.secSclk = 1'b1;
        n.secDiv  = 2'b00;
        n.secBit  = 4'h0;
        n.secIdx  = 4'h0;
      end
    end
    else if (q.secDiv == ess_pkg::SEC_DIV_LAST)
    begin
      // half period over: toggle the generated clock
      n.secDiv  = 2'b00;
      n.secSclk = ~q.secSclk;
      if (q.secSclk)
      begin
        // falling edge: present the next bit
        if (q.secBit != 4'h0)
        begin
          n.secSdo = q.secSh[14];
          n.secSh  = {q.secSh[13:0], 1'b0};
          n.secBit = q.secBit + 4'h1;
        end
        else if (q.secIdx == frameLen)
        begin
          // all words out: release select, park clock high
          n.secRun  = 1'b0;
          n.secCsN  = 1'b1;
          n.secSclk = 1'b1;
          n.secSdo  = 1'b0;
        end
        else
        begin
          n.secSdo = secData[15];
          n.secSh  = secData[14:0];
          n.secIdx = q.secIdx + 4'h1;
          n.secBit = 4'h1;
        end
      end
    end
    else
    begin
      n.secDiv = q.secDiv + 2'b01;
    end
  end

  // single state register; reset holds ready high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= ess_pkg::ESS_STATE_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // outputs straight from state
  assign sdo          = q.sdo;
  assign sdoOe        = ~q.csS2;
  assign frameReady_n = q.rdyN;
  assign frmIdx       = q.frmIdx;
  assign regWrStb     = q.wrStb;
  assign regWrAddr    = q.cmdAddr;
  assign regWrData    = q.cmdData;
  assign regRdAddr    = q.cmdAddr;
  assign secIdx       = q.secIdx;
  assign secSclk      = q.secSclk;
  assign secSdo       = q.secSdo;
  assign secCs_n      = q.secCsN;

  // checks on the port behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_sdo_hiz_desel: assert property (q.csS2 |-> !sdoOe)
    else $error("sdo driven while deselected");
  a_cs_ignore_in: assert property (
    q.csS2 && $past(q.csS2) |-> q.bitCnt == 5'h00)
    else $error("bits taken while deselected");
  a_rise_samples: assert property (
    riseEv && !q.csS2 && q.link == ess_pkg::LK_WORD && !q.diS2
    |=> q.bitCnt == $past(q.bitCnt) + 5'h01)
    else $error("rising edge did not take a bit");
  a_sdo_on_fall: assert property (!fallEv |=> $stable(q.sdo))
    else $error("sdo changed off a falling edge");
  a_hunt_entry: assert property (
    riseEv && !q.csS2 && q.diS2 && q.onesCnt == ess_pkg::ONES_LAST
    |=> q.link == ess_pkg::LK_HUNT)
    else $error("resync hunt not armed");
  a_write_commit: assert property (
    regWrStb |-> $past(csRise || startRs) && !q.wrPend)
    else $error("write committed at wrong point");
  a_frame_ready: assert property (
    frameAvail && q.framing |=> !frameReady_n)
    else $error("ready not low after frame");
  a_idle_ready: assert property (
    !q.framing && !$past(q.framing) && $past(arst_n)
    |-> !frameReady_n)
    else $error("ready high without framing");
  a_packet_drain: assert property (
    $fell(q.full) && q.framing && !$past(frameAvail)
    |-> $past(q.frmIdx) == frameLen - 4'h1)
    else $error("buffer emptied before last word");
  a_sec_select: assert property (!q.secRun |-> secCs_n && secSclk)
    else $error("secondary port active while idle");

  c_write_done: cover property (regWrStb);
  c_read_answer: cover property (q.rdPend ##[1:200] !q.rdPend);
  c_frame_drain: cover property ($fell(q.full));
  c_resync: cover property (q.link == ess_pkg::LK_HUNT);

endmodule : ess_serial_port

`default_nettype wire

// file: ess_host_model.sv
// Purpose: host side of the link, a serial master with a gated clock
// Assumes: 80 ns clock period, clock idles high outside words
// Notes:   no pull on the shared data line; released it reads inverted
`timescale 1ns/100ps
`default_nettype none

module ess_host_model
(
  output logic      cs_n,  // select to the port
  output logic      sclk,  // serial clock to the port
  output logic      sdi,   // serial data to the port
  input  wire logic sdo,   // port data out
  input  wire logic sdoOe  // port drive enable
);
  logic lastSdo;  // last driven level of the line
  logic sdoWire;  // line level as the host sees it

  initial
  begin
    cs_n    = 1'b1;
    sclk    = 1'b1;
    sdi     = 1'b0;
    lastSdo = 1'b0;
  end

  // keep the last driven level; a floating line must not look valid
  always @(sdo or sdoOe)
    if (sdoOe)
      lastSdo = sdo;
  // line is shared: ganged ports each need their own select and the
  // host must read them in turn at twice the rate
  assign sdoWire = sdoOe ? sdo : ~lastSdo;

  // send the top nb bits of tx msb first; hold keeps select low after
  task automatic xfer(input logic [31:0] tx, input int nb,
                      input logic hold, output logic [31:0] rx);
    int i;
    rx = '0;
    if (cs_n)
    begin
      cs_n = 1'b0;
      #50;
    end
    for (i = 31; i >= 32 - nb; i--)
    begin
      sclk = 1'b0;
      sdi  = tx[i];
      #40;
      sclk = 1'b1;
      #39;
      rx[i] = sdoWire;  // sampled just before the next fall
      #1;
    end
    if (!hold)
    begin
      cs_n = 1'b1;
      sdi  = ~sdi;  // deselected input shows no stale level
      #60;
    end
  endtask : xfer
endmodule : ess_host_model
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the serial slave port
// Assumes: host model drives the link, bench plays the core side
// Notes:   expected words come from the core model functions
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk, arst_n, frameAvail, secEn;  // bench driven
  logic [3:0]  frameLen;                         // words per frame
  logic        csN, sclk, sdi, sdo, sdoOe;       // link pins
  logic        frameReady_n, regWrStb;           // port status
  logic [3:0]  frmIdx, secIdx;                   // fetch indices
  logic [6:0]  frmAddr, regWrAddr, regRdAddr;    // addresses
  logic [23:0] frmData, regWrData, regRdData;    // data
  logic [15:0] secData;                          // secondary word
  logic        secSclk, secSdo, secCs_n, prevSck; // secondary pins
  logic [30:0] wrQ[$];   // seen register writes
  logic        secQ[$];  // seen secondary bits
  logic [31:0] rx, rx2;  // words read back
  logic [6:0]  a, b;     // random addresses
  logic [23:0] d;        // random data
  int          n_mismatch, n_checks, k, j, seed;

  // core model contents
  function automatic logic [6:0] fa(input logic [3:0] i);
    return 7'h10 + 7'(i);
  endfunction : fa
  function automatic logic [23:0] fd(input logic [3:0] i);
    return {4'ha, i, 16'h5c3e};
  endfunction : fd
  function automatic logic [23:0] rv(input logic [6:0] x);
    return {x, ~x, x, 3'h5};
  endfunction : rv
  function automatic logic [15:0] sd(input logic [3:0] i);
    return {4'hc, i, 8'h96};
  endfunction : sd
  assign frmAddr   = fa(frmIdx);
  assign frmData   = fd(frmIdx);
  assign regRdData = rv(regRdAddr);
  assign secData   = sd(secIdx);

  ess_serial_port dut (.clk(clk), .arst_n(arst_n), .cs_n(csN),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe),
    .frameReady_n(frameReady_n), .frameAvail(frameAvail),
    .frameLen(frameLen), .frmIdx(frmIdx), .frmAddr(frmAddr),
    .frmData(frmData), .regWrStb(regWrStb), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regRdAddr(regRdAddr),
    .regRdData(regRdData), .secEn(secEn), .secIdx(secIdx),
    .secData(secData), .secSclk(secSclk), .secSdo(secSdo),
    .secCs_n(secCs_n));
  ess_host_model host (.cs_n(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdoOe(sdoOe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // log register writes and secondary bits taken at secondary rises
  always @(posedge clk)
  begin
    if (regWrStb === 1'b1)
      wrQ.push_back({regWrAddr, regWrData});
    if (secCs_n === 1'b0 && secSclk && !prevSck)
      secQ.push_back(secSdo);
    prevSck <= secSclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for the next logged write, then compare it
  task automatic expWr(input logic [6:0] wa, input logic [23:0] wd);
    int t;
    for (t = 0; t < 100 && wrQ.size() == 0; t++)
      @(posedge clk);
    if (wrQ.size() == 0)
      n_mismatch++;  // bounded wait ran out
    else
      check(32'(wrQ.pop_front()), {1'b0, wa, wd});
  endtask : expWr

  task automatic pulseAvail();
    @(negedge clk) frameAvail = 1'b1;
    @(negedge clk) frameAvail = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulseAvail

  // hang guard
  initial
  begin
    #900000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    arst_n     = 1'b0;
    frameAvail = 1'b0;
    secEn      = 1'b0;
    frameLen   = 4'h3;
    seed = $urandom(32'h2638474c);
    repeat (3) @(negedge clk);
    check(frameReady_n, 1);
    check(sdoOe, 0);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check(frameReady_n, 0);
    // aborted half word must leave no trace, then write pairs
    wrQ.delete();
    host.xfer(32'hfe00_0000, 16, 1'b0, rx);
    repeat (10) @(negedge clk);
    check(32'(wrQ.size()), 0);
    for (k = 0; k < 4; k++)
    begin
      a = 7'h01 + 7'($urandom % 63);
      b = 7'h01 + 7'($urandom % 63);
      d = 24'($urandom);
      wrQ.delete();
      host.xfer({1'b1, a, d}, 32, 1'b1, rx);
      host.xfer({1'b1, b, ~d}, 32, 1'b0, rx);
      check(sdoOe, 0);
      expWr(a, d);
      expWr(b, ~d);
    end
    // back to back reads, each answered one word later
    a = 7'h01 + 7'($urandom % 63);
    host.xfer({1'b0, a, 24'h0}, 32, 1'b1, rx);
    for (k = 0; k < 3; k++)
    begin
      b = 7'h01 + 7'($urandom % 63);
      host.xfer({1'b0, b, 24'h0}, 32, 1'b1, rx);
      check(rx, {1'b0, a, rv(a)});
      a = b;
    end
    host.xfer(32'h0, 32, 1'b0, rx);
    check(rx, {1'b0, a, rv(a)});
    // framing with a write in mid-frame, select held low
    host.xfer({1'b0, ess_pkg::ADDR_FRAME, 24'h0}, 32, 1'b0, rx);
    check(frameReady_n, 1);
    pulseAvail();
    check(frameReady_n, 0);
    host.xfer(32'h0, 32, 1'b1, rx);
    check(rx, {1'b0, fa(0), fd(0)});
    wrQ.delete();
    host.xfer({1'b1, 7'h05, 24'h3c5a69}, 32, 1'b1, rx);
    check(rx, {1'b0, fa(1), fd(1)});
    check(frameReady_n, 0);
    host.xfer(32'h0, 32, 1'b0, rx);
    check(rx, {1'b0, fa(2), fd(2)});
    check(frameReady_n, 1);
    expWr(7'h05, 24'h3c5a69);
    // a plain read ends framing
    host.xfer({1'b0, 7'h22, 24'h0}, 32, 1'b0, rx);
    pulseAvail();
    check(frameReady_n, 0);
    // misaligned bits, 64 ones, then a read realigns the word
    host.xfer(32'($urandom) | 32'h8000_0000, 5, 1'b1, rx);
    host.xfer(32'hffff_ffff, 32, 1'b1, rx);
    host.xfer(32'hffff_ffff, 32, 1'b1, rx);
    a = 7'h01 + 7'($urandom % 63);
    host.xfer({1'b0, a, 24'h0}, 32, 1'b1, rx);
    host.xfer(32'h0, 32, 1'b0, rx2);
    check(rx2, {1'b0, a, rv(a)});
    // secondary master port sends frameLen words msb first
    secQ.delete();
    @(negedge clk) secEn = 1'b1;
    pulseAvail();
    check(secCs_n, 0);
    for (k = 0; k < 2000 && secCs_n !== 1'b1; k++)
      @(negedge clk);
    if (secCs_n !== 1'b1)
      n_mismatch++;  // bounded wait ran out
    check(secQ.size(), 48);
    for (k = 0; k < 3; k++)
    begin
      rx = '0;
      for (j = 0; j < 16 && secQ.size() > 0; j++)
        rx[15 - j] = secQ.pop_front();
      check(rx, 32'(sd(4'(k))));
    end
    secEn = 1'b0;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
